// file: src/ipu_pkg.sv
// Constants, register map and types for the interrupt priority unit
package ipu_pkg;

  // Vector space
  localparam int          NUM_VEC        = 32;
  localparam int          VEC_W          = 8;
  localparam logic [31:0] NMI_VEC_MASK   = 32'h0000_0002;
  localparam logic [7:0]  RESET_VEC      = 8'h00;

  // Printed register indices; byte address is four times the index
  localparam logic [1:0]  IDX_CONTROL    = 2'h0;
  localparam logic [1:0]  IDX_STATUS     = 2'h1;
  localparam logic [1:0]  IDX_PRIORITY   = 2'h2;
  localparam logic [1:0]  IDX_HIGH_VEC   = 2'h3;

  // Control field positions
  localparam int          CTL_ROTATE_BIT = 0;
  localparam int          CTL_COMPACT_BIT = 5;
  localparam int          CTL_LOCATE_BIT = 6;

  // Status field positions
  localparam int          ST_NORMAL_BIT  = 0;
  localparam int          ST_HIGH_BIT    = 1;
  localparam int          ST_NMI_BIT     = 7;

  // Reset values
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam logic [7:0]  PRIORITY_RST   = 8'h00;
  localparam logic [7:0]  HIGH_VEC_RST   = 8'h00;
  localparam logic [7:0]  HIGH_VEC_NONE  = 8'h00;

  // Compact table entries
  localparam logic [7:0]  CVT_NMI_VEC    = 8'h01;
  localparam logic [7:0]  CVT_HIGH_VEC   = 8'h02;
  localparam logic [7:0]  CVT_NORMAL_VEC = 8'h03;

  // Change guard: key value is arbitrary, window counted in instructions
  localparam logic [7:0]  IO_UNLOCK_KEY  = 8'hA5;
  localparam logic [2:0]  UNLOCK_INSTR   = 3'h4;

  // Program counter after system reset
  localparam logic [15:0] RESET_PC       = 16'h0000;

  // Presented request level, Gray coded
  typedef enum logic [1:0] {
    IPU_LVL_NONE   = 2'b00,
    IPU_LVL_NORMAL = 2'b01,
    IPU_LVL_HIGH   = 2'b11,
    IPU_LVL_NMI    = 2'b10
  } ipu_level_t;

endpackage : ipu_pkg

// file: src/ipu_controller.sv
// Interrupt priority unit with APB register slave
//
// Notes on behaviour
// - Among pending normal requests the highest priority wins.
// - Pointer vector gets lowest normal priority; pointer plus one highest.
// - Normal order wraps at top; reset and NMI always rank above.
// - Round robin writes each acknowledged normal vector into the pointer.
// - Control bit 0 selects fixed priority or round robin.
// - Compact table presents NMI at 1, high at 2, normal at 3.
// - Control bit 6 is vector location, bit 5 compact table enable.
// - Location 0 puts vectors after boot section, 1 at its start.
// - Location select ignored when all memory is boot section.
// - System reset always starts the program counter at zero.
// - Guarded bit writes without valid unlock leave them unchanged.
// - Round robin enable is writable at any time without unlock.
// - Status bit 7 set while NMI handler runs, cleared on its return.
// - Status bit 1 set while high handler runs, even if preempted.
// - Status bit 0 set while normal handler runs, even if preempted.
// - Each return restores exactly the level active before that handler.
// - High vector register names one vector; zero disables high level.
// - High request preempts normal handler, which resumes afterwards.
// - Nothing preempts NMI handler; simultaneous NMIs lowest vector first.
// - NMIs taken regardless of global enable and never change it.
//
// Chosen here: the APB slave port.

module ipu_controller
  import ipu_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_VEC-1:0] irq_req,
  input  wire logic               global_int_enable,
  input  wire logic               irq_ack,
  input  wire logic               interrupt_return_instruction_done,
  input  wire logic               guard_key_write,
  input  wire logic [7:0]         guard_key_data,
  input  wire logic               instr_retired,
  input  wire logic               flash_all_boot,
  output logic                    irq_valid,
  output logic      [VEC_W-1:0]   irq_vector,
  output ipu_level_t              irq_level,
  output logic                    vector_in_boot,
  output logic      [15:0]        reset_pc
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [7:0]       control;
  logic [7:0]       priority_ptr;
  logic [7:0]       high_vec;
  logic             nmi_active;
  logic             high_active;
  logic             normal_active;
  logic [2:0]       unlock_left;
  logic [VEC_W-1:0] src_vec;

  logic             rotate_en;
  logic             compact_en;
  logic             locate_boot;
  logic [7:0]       status_word;

  assign rotate_en   = control[CTL_ROTATE_BIT];
  assign compact_en  = control[CTL_COMPACT_BIT];
  assign locate_boot = control[CTL_LOCATE_BIT];

  // Status bits mirror the executing-level flags
  // Only the flags hold state; this word is a view of them
  always_comb begin
    status_word = 8'h00;
    status_word[ST_NMI_BIT]    = nmi_active;
    status_word[ST_HIGH_BIT]   = high_active;
    status_word[ST_NORMAL_BIT] = normal_active;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: no wait state; read data comes from a flop set at the end of setup

  logic       setup_phase;
  logic       access_done;
  logic       addr_ok;
  logic [1:0] reg_idx;
  logic [7:0] read_mux;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign addr_ok     = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'b00);
  assign reg_idx     = paddr[3:2];

  always_comb begin
    case (reg_idx)
      IDX_CONTROL:  read_mux = control;
      IDX_STATUS:   read_mux = status_word;
      IDX_PRIORITY: read_mux = priority_ptr;
      IDX_HIGH_VEC: read_mux = high_vec;
      default:      read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_ok;
      if (setup_phase && !pwrite && addr_ok) begin
        prdata <= {24'h00_0000, read_mux};
      end else if (setup_phase) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  logic wr_ctl;
  logic wr_pri;
  logic wr_hvec;

  // Status writes fall through silently; no error is flagged
  assign wr_ctl  = access_done & pwrite & addr_ok & (reg_idx == IDX_CONTROL);
  assign wr_pri  = access_done & pwrite & addr_ok & (reg_idx == IDX_PRIORITY);
  assign wr_hvec = access_done & pwrite & addr_ok & (reg_idx == IDX_HIGH_VEC);

  ////////////////////////////////////////////////////////////////////////////
  // Change guard window

  logic unlocked;
  assign unlocked = (unlock_left != 3'h0);

  // Any guarded write consumes the window, as does the fourth instruction
  // A fresh key restarts the window even when one is still open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_left <= 3'h0;
    end else if (clk_en) begin
      if (guard_key_write && guard_key_data == IO_UNLOCK_KEY) begin
        unlock_left <= UNLOCK_INSTR;
      end else if (wr_ctl) begin
        unlock_left <= 3'h0;
      end else if (instr_retired && unlocked) begin
        unlock_left <= unlock_left - 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CONTROL_RST;
    end else if (clk_en && wr_ctl) begin
      // Rotation bit is never guarded, so it is written unconditionally
      control[CTL_ROTATE_BIT] <= pwdata[CTL_ROTATE_BIT];
      if (unlocked) begin
        control[CTL_COMPACT_BIT] <= pwdata[CTL_COMPACT_BIT];
        control[CTL_LOCATE_BIT]  <= pwdata[CTL_LOCATE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request classification

  logic [NUM_VEC-1:0] high_mask;
  logic [NUM_VEC-1:0] normal_req;
  logic [NUM_VEC-1:0] nmi_req;
  logic               high_req;

  genvar g;
  generate
    for (g = 0; g < NUM_VEC; g++) begin : g_class
      // Zero never matches: it is the reset vector, not a request
      assign high_mask[g] = (high_vec != HIGH_VEC_NONE) &&
                            (high_vec == 8'(g));
    end
  endgenerate

  // Vector one is the only nonmaskable source; it never ranks as high
  assign nmi_req    = irq_req & NMI_VEC_MASK;
  assign high_req   = |(irq_req & high_mask & ~NMI_VEC_MASK);
  assign normal_req = irq_req & ~high_mask & ~NMI_VEC_MASK &
                      ~(NUM_VEC'(1) << RESET_VEC);

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Lowest numbered pending NMI first
  function automatic logic [VEC_W-1:0] pick_nmi(
    input logic [NUM_VEC-1:0] req
  );
    logic [VEC_W-1:0] hit;
    hit = 8'h00;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        hit = 8'(i);
      end
    end
    return hit;
  endfunction : pick_nmi

  // Scan from pointer plus one upward, wrapping; pointer itself comes last
  function automatic logic [VEC_W-1:0] pick_normal(
    input logic [NUM_VEC-1:0] req,
    input logic [7:0]         ptr
  );
    logic [VEC_W-1:0] hit;
    logic             found;
    int               idx;
    hit   = 8'h00;
    found = 1'b0;
    for (int i = 1; i <= NUM_VEC; i++) begin
      idx = (int'(ptr) + i) % NUM_VEC;
      if (!found && req[idx]) begin
        hit   = 8'(idx);
        found = 1'b1;
      end
    end
    return hit;
  endfunction : pick_normal

  logic             take_nmi;
  logic             take_high;
  logic             take_normal;
  logic [VEC_W-1:0] next_src;
  logic [VEC_W-1:0] next_vector;
  ipu_level_t       next_level;

  // NMI ignores global enable; nothing preempts a running NMI
  assign take_nmi    = (|nmi_req) && !nmi_active;
  assign take_high   = high_req && global_int_enable &&
                       !nmi_active && !high_active;
  assign take_normal = (|normal_req) && global_int_enable &&
                       !nmi_active && !high_active && !normal_active;

  // Compact mode changes only the presented vector, not the winner
  always_comb begin
    next_src    = 8'h00;
    next_vector = 8'h00;
    next_level  = IPU_LVL_NONE;
    if (take_nmi) begin
      next_src    = pick_nmi(nmi_req);
      next_level  = IPU_LVL_NMI;
      next_vector = compact_en ? CVT_NMI_VEC : next_src;
    end else if (take_high) begin
      next_src    = high_vec;
      next_level  = IPU_LVL_HIGH;
      next_vector = compact_en ? CVT_HIGH_VEC : next_src;
    end else if (take_normal) begin
      next_src    = pick_normal(normal_req, priority_ptr);
      next_level  = IPU_LVL_NORMAL;
      next_vector = compact_en ? CVT_NORMAL_VEC : next_src;
    end
  end

  // Offer refreshed every cycle; an ack refers to what is on the outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_valid  <= 1'b0;
      irq_vector <= 8'h00;
      irq_level  <= IPU_LVL_NONE;
      src_vec    <= 8'h00;
    end else if (clk_en) begin
      if (irq_ack && irq_valid) begin
        // Hold off one cycle so the offer reflects the new level flags
        irq_valid  <= 1'b0;
        irq_vector <= 8'h00;
        irq_level  <= IPU_LVL_NONE;
        src_vec    <= 8'h00;
      end else begin
        irq_valid  <= (next_level != IPU_LVL_NONE);
        irq_vector <= next_vector;
        irq_level  <= next_level;
        src_vec    <= next_src;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Executing-level flags

  logic ack_ok;
  assign ack_ok = irq_ack & irq_valid;

  // Return clears the innermost level only; an entry in the same cycle wins
  // Level flags stack, so a return needs no saved copy of the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_active    <= 1'b0;
      high_active   <= 1'b0;
      normal_active <= 1'b0;
    end else if (clk_en) begin
      if (interrupt_return_instruction_done) begin
        if (nmi_active) begin
          nmi_active <= 1'b0;
        end else if (high_active) begin
          high_active <= 1'b0;
        end else begin
          normal_active <= 1'b0;
        end
      end
      if (ack_ok) begin
        case (irq_level)
          IPU_LVL_NMI:    nmi_active    <= 1'b1;
          IPU_LVL_HIGH:   high_active   <= 1'b1;
          IPU_LVL_NORMAL: normal_active <= 1'b1;
          default:        ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority pointer and high vector

  // Hardware update wins over a software write in the same cycle
  // Values above the last vector wrap modulo the vector count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_ptr <= PRIORITY_RST;
    end else if (clk_en) begin
      if (ack_ok && rotate_en && irq_level == IPU_LVL_NORMAL) begin
        priority_ptr <= src_vec;
      end else if (wr_pri) begin
        priority_ptr <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_vec <= HIGH_VEC_RST;
    end else if (clk_en && wr_hvec) begin
      // Stored as written; names outside the vector range never match
      high_vec <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector location

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_in_boot <= 1'b0;
    end else if (clk_en) begin
      // Whole-boot layout leaves only one place for the table
      vector_in_boot <= locate_boot & ~flash_all_boot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset program counter

  // Fixed start address: location select must never move it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pc <= RESET_PC;
    end else if (clk_en) begin
      reset_pc <= RESET_PC;
    end
  end

endmodule : ipu_controller

// file: tb/ipu_checker_sva.sv
// Port checker for the interrupt priority unit
module ipu_checker
  import ipu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_ack,
  input wire logic        interrupt_return_instruction_done,
  input wire logic        global_int_enable,
  input wire logic        flash_all_boot,
  input wire logic        irq_valid,
  input wire logic [7:0]  irq_vector,
  input wire ipu_level_t  irq_level,
  input wire logic        vector_in_boot,
  input wire logic [15:0] reset_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_HI: assert property (prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_RESET_PC: assert property (reset_pc == RESET_PC)
    else $error("reset program counter not zero");
  AST_ALL_BOOT: assert property (flash_all_boot |=> !vector_in_boot)
    else $error("location select acts with all boot");
  AST_ACK_DROP: assert property (irq_valid && irq_ack |=> !irq_valid)
    else $error("offer stands after ack");
  // Nothing may be offered while the nonmaskable handler runs
  AST_NMI_HOLD: assert property ((irq_valid && irq_ack &&
    irq_level == IPU_LVL_NMI) ##1 !interrupt_return_instruction_done |=> !irq_valid)
    else $error("offer during nonmaskable handler");
  AST_MASK: assert property (irq_valid && !$past(global_int_enable)
    |-> irq_level == IPU_LVL_NMI)
    else $error("maskable offer with enable low");
  AST_NMI_VEC: assert property (irq_valid && irq_level == IPU_LVL_NMI
    |-> irq_vector == CVT_NMI_VEC)
    else $error("nonmaskable vector wrong");
  AST_NORM_VEC: assert property (irq_valid && irq_level == IPU_LVL_NORMAL
    |-> irq_vector > 8'h01)
    else $error("normal offer on reset or nmi vector");
  C_NMI: cover property (irq_valid && irq_ack && irq_level == IPU_LVL_NMI);
  C_HIGH: cover property (irq_valid && irq_ack && irq_level == IPU_LVL_HIGH);
  C_ERR: cover property (pslverr);
endmodule : ipu_checker

// file: tb/ipu_core_model.sv
// Processor core model: acks offers, returns, retires instructions
module ipu_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ack_en,
  input  wire logic [1:0] lag,
  input  wire logic       ret_go,
  input  wire logic       irq_valid,
  output logic            irq_ack,
  output logic            interrupt_return_instruction_done,
  output logic            instr_retired
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  // Lag lets an offer stand a few cycles, as a busy core would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      irq_ack <= 1'b0;
      if (!irq_valid || irq_ack) begin
        wait_cnt <= 2'h0;
      end else if (ack_en && wait_cnt == lag) begin
        irq_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
  // One instruction every second cycle paces the unlock window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_retired <= 1'b0;
      interrupt_return_instruction_done <= 1'b0;
    end else begin
      instr_retired <= !instr_retired;
      interrupt_return_instruction_done <= ret_go;
    end
  end
endmodule : ipu_core_model

// file: tb/testbench.sv
// Self-checking bench for the interrupt priority unit
module testbench
  import ipu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] req;
    logic [7:0]  ptr;
    logic [7:0]  hv;
    logic        ie;
    logic [7:0]  vec;
    ipu_level_t  lvl;
  } ipu_row_t;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NUM_VEC-1:0] irq_req;
  logic global_int_enable, irq_ack, interrupt_return_instruction_done, guard_key_write;
  logic [7:0] guard_key_data, rd;
  logic instr_retired, flash_all_boot, irq_valid, vector_in_boot, er;
  logic [VEC_W-1:0] irq_vector;
  ipu_level_t irq_level;
  logic [15:0] reset_pc;
  logic ack_en, ret_go;
  logic [1:0] lag;
  int n_errors, cmp_count;
  ipu_row_t rows [8] = '{
    '{32'h30, 8'h00, 8'h00, 1'b1, 8'h04, IPU_LVL_NORMAL},
    '{32'h30, 8'h04, 8'h00, 1'b1, 8'h05, IPU_LVL_NORMAL},
    '{32'h80000008, 8'h1F, 8'h00, 1'b1, 8'h03, IPU_LVL_NORMAL},
    '{32'h80000008, 8'h05, 8'h00, 1'b1, 8'h1F, IPU_LVL_NORMAL},
    '{32'h98, 8'h00, 8'h07, 1'b1, 8'h07, IPU_LVL_HIGH},
    '{32'h9A, 8'h00, 8'h07, 1'b1, 8'h01, IPU_LVL_NMI},
    '{32'h12, 8'h00, 8'h00, 1'b0, 8'h01, IPU_LVL_NMI},
    '{32'h10, 8'h00, 8'h00, 1'b0, 8'h00, IPU_LVL_NONE}};
  ipu_controller u_ipu_controller (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq_req, .global_int_enable, .irq_ack, .interrupt_return_instruction_done, .guard_key_write,
    .guard_key_data, .instr_retired, .flash_all_boot, .irq_valid,
    .irq_vector, .irq_level, .vector_in_boot, .reset_pc);
  ipu_core_model u_ipu_core_model (.pclk, .presetn, .ack_en, .lag,
    .ret_go, .irq_valid, .irq_ack, .interrupt_return_instruction_done, .instr_retired);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wack();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (irq_ack !== 1'b1 && k < 20);
    chk(8'(k < 20), 8'h01);
  endtask : wack
  task automatic interrupt_return_instruction();
    ret_go <= 1'b1;
    @(posedge pclk);
    ret_go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : interrupt_return_instruction
  task automatic key();
    guard_key_data <= IO_UNLOCK_KEY;
    guard_key_write <= 1'b1;
    @(posedge pclk);
    guard_key_write <= 1'b0;
  endtask : key
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (4000) @(posedge pclk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog", $time);
    summarize();
  end
  initial begin
    {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
    {irq_req, global_int_enable, guard_key_write, guard_key_data} = '0;
    {flash_all_boot, ack_en, ret_go, lag} = '0;
    n_errors = 0;
    cmp_count = 0;
    clk_en = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      apb(1'b0, 12'(a * 4), 8'h00);
      chk(rd, 8'h00);
    end
    apb(1'b0, 12'h010, 8'h00);
    chk(8'(er), 8'h01);
    foreach (rows[i]) begin
      apb(1'b1, 12'h008, rows[i].ptr);
      apb(1'b1, 12'h00C, rows[i].hv);
      global_int_enable <= rows[i].ie;
      irq_req <= rows[i].req;
      repeat (3) @(posedge pclk);
      chk(8'(irq_level), 8'(rows[i].lvl));
      if (rows[i].lvl != IPU_LVL_NONE)
        chk(irq_vector, rows[i].vec);
      irq_req <= '0;
      repeat (2) @(posedge pclk);
    end
    // Nesting: normal, then high, then nonmaskable
    global_int_enable <= 1'b1;
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b1, 12'h00C, 8'h00);
    apb(1'b1, 12'h000, 8'h01);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h01);
    ack_en <= 1'b1;
    lag <= 2'h2;
    irq_req <= 32'h50;
    wack();
    irq_req <= 32'h40;
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 8'h01);
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 8'h04);
    apb(1'b1, 12'h00C, 8'h06);
    wack();
    irq_req <= 32'h02;
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 8'h03);
    wack();
    irq_req <= '0;
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 8'h83);
    interrupt_return_instruction();
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 8'h03);
    interrupt_return_instruction();
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 8'h01);
    interrupt_return_instruction();
    apb(1'b0, 12'h004, 8'h00);
    chk(rd, 8'h00);
    // Guarded bits: refused, accepted, window expired
    apb(1'b1, 12'h000, 8'h61);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h01);
    key();
    apb(1'b1, 12'h000, 8'h61);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h61);
    chk(8'(vector_in_boot), 8'h01);
    flash_all_boot <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(8'(vector_in_boot), 8'h00);
    flash_all_boot <= 1'b0;
    key();
    repeat (12) @(posedge pclk);
    apb(1'b1, 12'h000, 8'h01);
    apb(1'b0, 12'h000, 8'h00);
    chk(rd, 8'h61);
    lag <= 2'h0;
    irq_req <= 32'h20;
    wack();
    chk(irq_vector, CVT_NORMAL_VEC);
    irq_req <= '0;
    apb(1'b0, 12'h008, 8'h00);
    chk(rd, 8'h05);
    interrupt_return_instruction();
    // Frozen unit offers nothing; release lets the offer through
    clk_en <= 1'b0;
    irq_req <= 32'h20;
    repeat (4) @(posedge pclk);
    chk(8'(irq_valid), 8'h00);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(8'(irq_valid), 8'h01);
    irq_req <= '0;
    repeat (2) @(posedge pclk);
    // Mid-run reset must bring every register back to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      apb(1'b0, 12'(b * 4), 8'h00);
      chk(rd, 8'h00);
    end
    chk(8'(vector_in_boot), 8'h00);
    summarize();
  end
endmodule : testbench
bind ipu_controller ipu_checker u_ipu_checker (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .irq_ack, .interrupt_return_instruction_done,
  .global_int_enable, .flash_all_boot, .irq_valid, .irq_vector,
  .irq_level, .vector_in_boot, .reset_pc);
